// *** inc/cac_pkg.sv ***
package cac_pkg;

    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_POWER   = 16'h0610;
    localparam logic [15:0] OFS_SHUTTER = 16'h081C;
    localparam logic [15:0] OFS_GAIN    = 16'h0820;
    localparam logic [15:0] OFS_COMP    = 16'h1E80;
    localparam logic [15:0] OFS_BUFUSE  = 16'h1E84;

    // ------------------------------------------------------------
    // Field positions, quadlet bit n sits at vector bit 31-n
    // ------------------------------------------------------------
    localparam int PWR_BIT     = 31;
    localparam int PRES_BIT    = 31;
    localparam int ONEPUSH_BIT = 26;
    localparam int ON_BIT      = 25;
    localparam int AUTO_BIT    = 24;
    localparam int FEAT_W      = 12;
    localparam int QUAL_W      = 8;
    localparam int USE_W       = 7;

    // ------------------------------------------------------------
    // Values and limits
    // ------------------------------------------------------------
    localparam logic [1:0]  DISCARD_FRAMES = 2'h2;
    localparam int          SHUT_MAX_CODE  = 4095;
    localparam int          GAIN_MAX_MDB   = 24000;
    localparam int          GAIN_STEP_MDB  = 46;
    localparam int          GAIN_MAX_CODE  = GAIN_MAX_MDB / GAIN_STEP_MDB;
    localparam logic [11:0] FEAT_RESET_VAL = 12'h000;
    localparam logic [7:0]  QUAL_MIN       = 8'h01;
    localparam logic [7:0]  QUAL_MAX       = 8'h64;
    localparam logic [7:0]  QUAL_ZERO_AS   = 8'h3C;
    localparam logic [6:0]  USE_FULL       = 7'h7F;
    localparam logic [6:0]  USE_ZERO_OLD   = 7'h66;
    localparam logic [6:0]  USE_ZERO_NEW   = 7'h72;
    localparam logic [2:0]  MODE_LAST_SW   = 3'h3;
    localparam logic [2:0]  MODE_FIRST_FIX = 3'h6;

    // ------------------------------------------------------------
    // Timing at 250 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 4;
    localparam int EXP_MIN_NS      = 10000;
    localparam int EXP_MAX_MS      = 4200;
    localparam int EXP_MIN_CYC     =
        (EXP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXP_MAX_CYC_DEF = EXP_MAX_MS * (1000000 / CLK_PERIOD_NS);
    localparam int FRAME_PERIOD_DEF = 16666666;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } cac_bus_req_t;

endpackage : cac_pkg

// *** hdl/cac_acquisition_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module cac_acquisition_ctrl #(
    parameter int unsigned FRAME_PERIOD_CYC = cac_pkg::FRAME_PERIOD_DEF,
    parameter int unsigned EXP_MAX_CYC      = cac_pkg::EXP_MAX_CYC_DEF,
    parameter bit          LATE_FIRMWARE    = 1'b1
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire cac_pkg::cac_bus_req_t regReq,
    output logic [31:0]                regRdata_reg,
    output logic                       regRvalid_reg,
    input  wire logic                  isoEnable,
    input  wire logic                  singleFrameRequest,
    input  wire logic                  burstFrameRequest,
    input  wire logic [2:0]            imagingMode,
    input  wire logic [3:0]            frameRateDivider,
    input  wire logic [1:0]            autoValid,
    input  wire logic [1:0][11:0]      autoValue,
    input  wire logic [1:0]            onePushDone,
    input  wire logic                  compSizeValid,
    input  wire logic [23:0]           compFrameBytes,
    input  wire logic [23:0]           hostBufferBytes,
    output logic                       cameraPower_reg,
    output logic                       autoExposureRun_reg,
    output logic                       sensorExpose_reg,
    output logic                       frameReadout_reg,
    output logic                       frameSend_reg,
    output logic [31:0]                exposureCycles_reg,
    output logic [11:0]                gainCode_reg,
    output logic                       compressEnable_reg,
    output logic [7:0]                 qualityEff_reg,
    output logic [6:0]                 bufferTarget_reg
);

    localparam int unsigned EXP_UNIT = EXP_MAX_CYC / cac_pkg::SHUT_MAX_CODE;

    logic                  xmitReq;
    logic                  powerNext;
    logic                  frameEndNow;
    logic [1:0]            discardLeft_reg;
    logic [31:0]           periodCnt_reg;
    logic [31:0]           periodLen;
    logic [3:0]            divEff;
    logic [35:0]           expProduct;
    logic [31:0]           expNext;
    logic [1:0]            featOnePush_reg;
    logic [1:0]            featOn_reg;
    logic [1:0]            featAuto_reg;
    logic [1:0][11:0]      featValue_reg;
    logic [1:0]            featWr;
    logic                  compWr;
    logic                  bufWr;
    logic                  compOn_reg;
    logic                  compAuto_reg;
    logic [7:0]            compQual_reg;
    logic [7:0]            qualNow;
    logic [6:0]            bufVal_reg;
    logic [30:0]           fillNeed;
    logic [30:0]           fillAllow;
    logic [31:0]           rdData;

    // ------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------
    assign xmitReq = isoEnable | singleFrameRequest | burstFrameRequest;

    always_comb begin
        powerNext = cameraPower_reg;
        if (regReq.wr && regReq.addr == cac_pkg::OFS_POWER) begin
            powerNext = regReq.wdata[cac_pkg::PWR_BIT];
        end
        if (xmitReq) begin
            powerNext = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cameraPower_reg <= 1'b0;
        end else begin
            cameraPower_reg <= powerNext;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            autoExposureRun_reg <= 1'b0;
        end else begin
            autoExposureRun_reg <= cameraPower_reg;
        end
    end

    // ------------------------------------------------------------
    // Frame timing and exposure
    // ------------------------------------------------------------
    assign divEff = (frameRateDivider == 4'h0) ? 4'h1 : frameRateDivider;
    assign periodLen = 32'(FRAME_PERIOD_CYC * divEff);
    assign frameEndNow = cameraPower_reg && periodCnt_reg == 32'h1;

    always_ff @(posedge clk) begin
        if (reset || !cameraPower_reg) begin
            periodCnt_reg <= '0;
        end else if (periodCnt_reg <= 32'h1) begin
            periodCnt_reg <= periodLen;
        end else begin
            periodCnt_reg <= periodCnt_reg - 32'h1;
        end
    end

    assign expProduct = 36'(featValue_reg[0]) * 36'(EXP_UNIT) * 36'(divEff);

    always_comb begin
        if (expProduct < 36'(cac_pkg::EXP_MIN_CYC)) begin
            expNext = 32'(cac_pkg::EXP_MIN_CYC);
        end else if (expProduct[35:32] != 4'h0) begin
            expNext = 32'hFFFFFFFF;
        end else begin
            expNext = expProduct[31:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            exposureCycles_reg <= 32'(cac_pkg::EXP_MIN_CYC);
            sensorExpose_reg   <= 1'b0;
            frameReadout_reg   <= 1'b0;
        end else begin
            exposureCycles_reg <= expNext;
            sensorExpose_reg   <= cameraPower_reg && periodCnt_reg != '0
                                  && periodCnt_reg <= exposureCycles_reg;
            frameReadout_reg   <= frameEndNow;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            discardLeft_reg <= '0;
            frameSend_reg   <= 1'b0;
        end else begin
            if (powerNext && !cameraPower_reg) begin
                discardLeft_reg <= cac_pkg::DISCARD_FRAMES;
            end else if (frameEndNow && discardLeft_reg != '0) begin
                discardLeft_reg <= discardLeft_reg - 2'h1;
            end
            frameSend_reg <= frameEndNow && discardLeft_reg == '0 && xmitReq;
        end
    end

    // ------------------------------------------------------------
    // Shutter and gain controls
    // ------------------------------------------------------------
    for (genvar f = 0; f < 2; f++) begin : g_feat
        localparam logic [15:0] OFS =
            (f == 0) ? cac_pkg::OFS_SHUTTER : cac_pkg::OFS_GAIN;
        localparam logic [11:0] LIM = (f == 0) ?
            12'(cac_pkg::SHUT_MAX_CODE) : 12'(cac_pkg::GAIN_MAX_CODE);
        logic [11:0] wrVal;
        logic [11:0] autoVal;

        assign featWr[f] = regReq.wr && regReq.addr == OFS;
        assign wrVal   = (regReq.wdata[11:0] > LIM) ? LIM :
                         regReq.wdata[11:0];
        assign autoVal = (autoValue[f] > LIM) ? LIM : autoValue[f];

        always_ff @(posedge clk) begin
            if (reset) begin
                featOn_reg[f]    <= 1'b1;
                featAuto_reg[f]  <= 1'b0;
                featValue_reg[f] <= cac_pkg::FEAT_RESET_VAL;
            end else if (featWr[f]) begin
                featOn_reg[f]    <= regReq.wdata[cac_pkg::ON_BIT];
                featAuto_reg[f]  <= regReq.wdata[cac_pkg::AUTO_BIT];
                featValue_reg[f] <= wrVal;
            end else if (cameraPower_reg && autoValid[f]
                         && (featAuto_reg[f] || featOnePush_reg[f])) begin
                featValue_reg[f] <= autoVal;
            end
        end

        // A new one-push request wins over a completion in the same cycle.
        always_ff @(posedge clk) begin
            if (reset) begin
                featOnePush_reg[f] <= 1'b0;
            end else if (featWr[f] && regReq.wdata[cac_pkg::ONEPUSH_BIT]) begin
                featOnePush_reg[f] <= 1'b1;
            end else if (onePushDone[f]) begin
                featOnePush_reg[f] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gainCode_reg <= cac_pkg::FEAT_RESET_VAL;
        end else begin
            gainCode_reg <= featValue_reg[1];
        end
    end

    // ------------------------------------------------------------
    // Compression quality
    // ------------------------------------------------------------
    assign compWr = regReq.wr && regReq.addr == cac_pkg::OFS_COMP;
    assign bufWr  = regReq.wr && regReq.addr == cac_pkg::OFS_BUFUSE;
    assign qualNow = (compQual_reg == 8'h00) ? cac_pkg::QUAL_ZERO_AS :
                     compQual_reg;
    assign fillNeed  = 31'(compFrameBytes) * 31'(cac_pkg::USE_FULL);
    assign fillAllow = 31'(hostBufferBytes) * 31'(bufferTarget_reg);

    always_ff @(posedge clk) begin
        if (reset) begin
            compOn_reg   <= 1'b0;
            compAuto_reg <= 1'b0;
        end else if (compWr) begin
            compOn_reg <= regReq.wdata[cac_pkg::ON_BIT];
            if (compOn_reg) begin
                compAuto_reg <= regReq.wdata[cac_pkg::AUTO_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            compQual_reg <= 8'h00;
        end else if (compWr && compOn_reg && !compAuto_reg) begin
            if (regReq.wdata[7:0] > cac_pkg::QUAL_MAX) begin
                compQual_reg <= cac_pkg::QUAL_MAX;
            end else begin
                compQual_reg <= regReq.wdata[7:0];
            end
        end else if (compAuto_reg && compressEnable_reg && compSizeValid) begin
            if (fillNeed > fillAllow && qualNow > cac_pkg::QUAL_MIN) begin
                compQual_reg <= qualNow - 8'h01;
            end else if (fillNeed < fillAllow
                         && qualNow < cac_pkg::QUAL_MAX) begin
                compQual_reg <= qualNow + 8'h01;
            end else begin
                compQual_reg <= qualNow;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            compressEnable_reg <= 1'b0;
            qualityEff_reg     <= cac_pkg::QUAL_ZERO_AS;
        end else begin
            if (imagingMode <= cac_pkg::MODE_LAST_SW) begin
                compressEnable_reg <= compOn_reg;
            end else begin
                compressEnable_reg <= imagingMode >= cac_pkg::MODE_FIRST_FIX;
            end
            qualityEff_reg <= qualNow;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bufVal_reg       <= 7'h00;
            bufferTarget_reg <= cac_pkg::USE_ZERO_NEW;
        end else begin
            if (bufWr) begin
                bufVal_reg <= regReq.wdata[6:0];
            end
            if (bufVal_reg != 7'h00) begin
                bufferTarget_reg <= bufVal_reg;
            end else if (LATE_FIRMWARE) begin
                bufferTarget_reg <= cac_pkg::USE_ZERO_NEW;
            end else begin
                bufferTarget_reg <= cac_pkg::USE_ZERO_OLD;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------
    function automatic logic featIdx();
        featIdx = regReq.addr == cac_pkg::OFS_GAIN;
    endfunction : featIdx

    always_comb begin
        rdData = '0;
        case (regReq.addr)
            cac_pkg::OFS_POWER: begin
                rdData[cac_pkg::PWR_BIT] = cameraPower_reg;
            end
            cac_pkg::OFS_SHUTTER, cac_pkg::OFS_GAIN: begin
                rdData[cac_pkg::PRES_BIT]    = 1'b1;
                rdData[cac_pkg::ONEPUSH_BIT] = featOnePush_reg[featIdx()];
                rdData[cac_pkg::ON_BIT]      = featOn_reg[featIdx()];
                rdData[cac_pkg::AUTO_BIT]    = featAuto_reg[featIdx()];
                rdData[11:0]                 = featValue_reg[featIdx()];
            end
            cac_pkg::OFS_COMP: begin
                rdData[cac_pkg::PRES_BIT] = 1'b1;
                rdData[cac_pkg::ON_BIT]   = compOn_reg;
                rdData[cac_pkg::AUTO_BIT] = compAuto_reg;
                rdData[7:0]               = compQual_reg;
            end
            cac_pkg::OFS_BUFUSE: begin
                rdData[cac_pkg::PRES_BIT] = 1'b1;
                rdData[6:0]               = bufVal_reg;
            end
            default: begin
                rdData = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            regRdata_reg  <= '0;
            regRvalid_reg <= 1'b0;
        end else begin
            regRvalid_reg <= regReq.rd;
            if (regReq.rd) begin
                regRdata_reg <= rdData;
            end
        end
    end

endmodule : cac_acquisition_ctrl
`default_nettype wire

// *** bench/cac_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cac_host_model (
    input  wire logic                  clk,
    output var cac_pkg::cac_bus_req_t  regReq,
    input  wire logic [31:0]           regRdata_reg,
    input  wire logic                  regRvalid_reg
);
    initial regReq = '0;

    // Released lines show the inverse so stale values never pass.
    task automatic idle();
        regReq.wr = 1'h0;
        regReq.rd = 1'h0;
        regReq.addr = ~regReq.addr;
        regReq.wdata = ~regReq.wdata;
    endtask : idle

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        regReq.wr = 1'h1;
        regReq.addr = a;
        regReq.wdata = d;
        @(negedge clk);
        idle();
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        int n = 0;
        @(negedge clk);
        regReq.rd = 1'h1;
        regReq.addr = a;
        @(negedge clk);
        idle();
        while (regRvalid_reg !== 1'h1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = (regRvalid_reg === 1'h1) ? regRdata_reg : 'x;
    endtask : rd
endmodule : cac_host_model
`default_nettype wire

// *** bench/cac_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module cac_checker (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire cac_pkg::cac_bus_req_t regReq,
    input wire logic [31:0]           regRdata_reg,
    input wire logic                  regRvalid_reg,
    input wire logic                  isoEnable,
    input wire logic                  singleFrameRequest,
    input wire logic                  burstFrameRequest,
    input wire logic [2:0]            imagingMode,
    input wire logic                  cameraPower_reg,
    input wire logic                  autoExposureRun_reg,
    input wire logic                  frameReadout_reg,
    input wire logic                  frameSend_reg,
    input wire logic [31:0]           exposureCycles_reg,
    input wire logic [11:0]           gainCode_reg,
    input wire logic                  compressEnable_reg,
    input wire logic [7:0]            qualityEff_reg,
    input wire logic [6:0]            bufferTarget_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Readouts seen since power-up, saturating at two.
    logic [1:0] seenCnt_reg;
    always_ff @(posedge clk) begin
        if (reset || !cameraPower_reg) begin
            seenCnt_reg <= 2'h0;
        end else if (frameReadout_reg && seenCnt_reg != 2'h2) begin
            seenCnt_reg <= seenCnt_reg + 2'h1;
        end
    end

    sequence txStart;
        isoEnable || singleFrameRequest || burstFrameRequest;
    endsequence
    sequence presRead;
        regReq.rd && (regReq.addr == cac_pkg::OFS_COMP ||
                      regReq.addr == cac_pkg::OFS_BUFUSE);
    endsequence
    sequence darkTwo;
        !cameraPower_reg ##1 !cameraPower_reg;
    endsequence

    tx_power_a: assert property (txStart |=> cameraPower_reg)
        else $error("transmit enable left camera unpowered");
    power_hold_a: assert property (cameraPower_reg &&
        !(regReq.wr && regReq.addr == cac_pkg::OFS_POWER) |=> cameraPower_reg)
        else $error("camera power dropped without a write");
    ae_halt_a: assert property (!cameraPower_reg |=> !autoExposureRun_reg)
        else $error("auto exposure running while unpowered");
    dark_sensor_a: assert property (darkTwo |-> !frameReadout_reg)
        else $error("readout while unpowered");
    discard_two_a: assert property (frameSend_reg |->
        frameReadout_reg && seenCnt_reg == 2'h2)
        else $error("frame sent among first two after power-up");
    read_answer_a: assert property (1'h1 |=>
        regRvalid_reg == $past(regReq.rd))
        else $error("read answer not one cycle after request");
    presence_bit_a: assert property (presRead |=>
        regRdata_reg[31] && regRdata_reg[30:26] == 5'h00)
        else $error("presence or reserved bits wrong");
    quality_range_a: assert property (qualityEff_reg >= cac_pkg::QUAL_MIN &&
        qualityEff_reg <= cac_pkg::QUAL_MAX)
        else $error("effective quality out of range");
    usage_nonzero_a: assert property (bufferTarget_reg != 7'h00)
        else $error("usage target zero");
    gain_ceiling_a: assert property (gainCode_reg <= 12'h209)
        else $error("gain code above ceiling");
    expo_floor_a: assert property (exposureCycles_reg >= 32'h000009C4)
        else $error("exposure below minimum");
    fixed_mode_a: assert property (imagingMode[2:1] == 2'h3 |=>
        compressEnable_reg)
        else $error("compression off in fixed mode");
endmodule : cac_checker
`default_nettype wire

// *** bench/test_camera_acquisition_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_camera_acquisition_control;
    localparam int PERIOD = 4000;
    localparam logic [31:0] CW [7] = '{32'h00000050, 32'h02000000,
        32'h02000050, 32'h02000000, 32'h02000070, 32'h03000064, 32'h03000020};
    localparam logic [31:0] CR [7] = '{32'h80000000, 32'h82000000,
        32'h82000050, 32'h82000000, 32'h82000064, 32'h83000064, 32'h83000064};
    localparam logic [7:0]  QE [7] = '{8'h3C, 8'h3C, 8'h50, 8'h3C, 8'h64,
        8'h64, 8'h64};
    localparam logic [6:0]  UW [3] = '{7'h6E, 7'h00, 7'h7F};
    localparam logic [6:0]  UE [3] = '{7'h6E, 7'h72, 7'h7F};

    logic                  clk = 1'h0;
    logic                  reset = 1'h1;
    cac_pkg::cac_bus_req_t regReq;
    logic [31:0]           regRdata_reg, exposureCycles_reg, rv;
    logic                  regRvalid_reg, cameraPower_reg, frameSend_reg;
    logic                  autoExposureRun_reg, sensorExpose_reg;
    logic                  frameReadout_reg, compressEnable_reg;
    logic [11:0]           gainCode_reg;
    logic [7:0]            qualityEff_reg;
    logic [6:0]            bufferTarget_reg;
    logic                  isoEnable = 1'h0;
    logic                  singleFrameRequest = 1'h0;
    logic                  burstFrameRequest = 1'h0;
    logic [2:0]            imagingMode = 3'h0;
    logic [3:0]            frameRateDivider = 4'h1;
    logic [1:0]            autoValid = 2'h0;
    logic [1:0][11:0]      autoValue = '0;
    logic [1:0]            onePushDone = 2'h0;
    logic                  compSizeValid = 1'h0;
    logic [23:0]           compFrameBytes = 24'h0003E8;
    logic [23:0]           hostBufferBytes = 24'h0003E8;
    int                    bad_count = 0;
    int                    n_tests = 0;
    int                    sends, expo, gap;

    always #2 clk = ~clk;

    cac_acquisition_ctrl #(.FRAME_PERIOD_CYC(PERIOD), .EXP_MAX_CYC(40950),
        .LATE_FIRMWARE(1'h1)) uut (.clk, .reset, .regReq, .regRdata_reg,
        .regRvalid_reg, .isoEnable, .singleFrameRequest, .burstFrameRequest,
        .imagingMode, .frameRateDivider, .autoValid, .autoValue, .onePushDone,
        .compSizeValid, .compFrameBytes, .hostBufferBytes, .cameraPower_reg,
        .autoExposureRun_reg, .sensorExpose_reg, .frameReadout_reg,
        .frameSend_reg, .exposureCycles_reg, .gainCode_reg,
        .compressEnable_reg, .qualityEff_reg, .bufferTarget_reg);
    cac_host_model host (.clk, .regReq, .regRdata_reg, .regRvalid_reg);

    task automatic chkv(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chkv
    task automatic chkn(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            bad_count++;
            $display("FAIL %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chkn
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic rdchk(input string nm, input logic [15:0] a,
                         input logic [31:0] e);
        host.rd(a, rv);
        chkv(nm, e, rv);
    endtask : rdchk
    task automatic autop(input int f, input logic [11:0] v);
        @(negedge clk);
        autoValid[f] = 1'h1;
        autoValue[f] = v;
        @(negedge clk);
        autoValid = 2'h0;
        autoValue = ~autoValue;
        cyc(2);
    endtask : autop
    task automatic sizep(input logic [23:0] b);
        @(negedge clk);
        compFrameBytes = b;
        compSizeValid = 1'h1;
        @(negedge clk);
        compSizeValid = 1'h0;
        compFrameBytes = ~b;
        cyc(1);
    endtask : sizep
    task automatic run_frames(input int n, output int s, output int e,
                              output int p);
        int k = 0, c = 0, last = 0, acc = 0;
        s = 0;
        e = 0;
        p = 0;
        while (k < n && c < 3 * n * PERIOD) begin
            @(negedge clk);
            c++;
            acc += int'(sensorExpose_reg === 1'h1);
            s += int'(frameSend_reg === 1'h1);
            if (frameReadout_reg === 1'h1) begin
                k++;
                p = c - last;
                last = c;
                e = acc;
                acc = 0;
            end
        end
    endtask : run_frames
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // The whole run needs about 24500 cycles.
    initial begin
        cyc(90000);
        bad_count++;
        close_out();
    end

    initial begin
        cyc(16);
        reset = 1'h0;
        chkv("power", 32'h0, cameraPower_reg);
        rdchk("pwrReg", cac_pkg::OFS_POWER, 32'h0);
        rdchk("useReg", cac_pkg::OFS_BUFUSE, 32'h80000000);
        rdchk("unmapped", 16'h0614, 32'h0);
        chkv("target", 32'h72, bufferTarget_reg);
        for (int i = 0; i < 7; i++) begin
            host.wr(cac_pkg::OFS_COMP, CW[i]);
            rdchk("compReg", cac_pkg::OFS_COMP, CR[i]);
            chkv("qualEff", QE[i], qualityEff_reg);
        end
        chkv("compEn", 32'h1, compressEnable_reg);
        sizep(24'h0003E8);
        rdchk("autoQual", cac_pkg::OFS_COMP, 32'h83000063);
        sizep(24'h000064);
        chkv("autoQual", 32'h64, qualityEff_reg);
        host.wr(cac_pkg::OFS_COMP, 32'h0);
        for (int m = 0; m < 8; m++) begin
            imagingMode = 3'(m);
            cyc(2);
            chkv("modeComp", 32'(m >= 6), compressEnable_reg);
        end
        imagingMode = 3'h0;
        for (int i = 0; i < 3; i++) begin
            host.wr(cac_pkg::OFS_BUFUSE, {25'h0, UW[i]});
            rdchk("useReg", cac_pkg::OFS_BUFUSE, {25'h1000000, UW[i]});
            chkv("target", 32'(UE[i]), bufferTarget_reg);
        end
        host.wr(cac_pkg::OFS_GAIN, 32'h02000FFF);
        cyc(2);
        chkv("gain", 32'h209, gainCode_reg);
        host.wr(cac_pkg::OFS_GAIN, 32'h03000209);
        autop(1, 12'h050);
        chkv("gainOff", 32'h209, gainCode_reg);
        host.wr(cac_pkg::OFS_SHUTTER, 32'h02000010);
        cyc(2);
        chkv("expoMin", 32'h9C4, exposureCycles_reg);
        host.wr(cac_pkg::OFS_SHUTTER, 32'h0200012C);
        frameRateDivider = 4'h2;
        cyc(3);
        chkv("expoDiv", 32'h1770, exposureCycles_reg);
        frameRateDivider = 4'h1;
        cyc(3);
        chkv("expo", 32'hBB8, exposureCycles_reg);
        isoEnable = 1'h1;
        cyc(1);
        chkv("power", 32'h1, cameraPower_reg);
        rdchk("pwrReg", cac_pkg::OFS_POWER, 32'h80000000);
        autop(1, 12'h050);
        chkv("gainAuto", 32'h50, gainCode_reg);
        host.wr(cac_pkg::OFS_GAIN, 32'h06000010);
        autop(1, 12'h060);
        chkv("gainPush", 32'h60, gainCode_reg);
        onePushDone = 2'h2;
        cyc(1);
        onePushDone = 2'h0;
        rdchk("gainReg", cac_pkg::OFS_GAIN, 32'h82000060);
        host.wr(cac_pkg::OFS_GAIN, 32'h02000010);
        autop(1, 12'h070);
        chkv("gainMan", 32'h10, gainCode_reg);
        run_frames(4, sends, expo, gap);
        chkn("sends", 2, sends);
        chkn("gap", PERIOD, gap);
        chkn("expoLen", 3000, expo);
        isoEnable = 1'h0;
        run_frames(2, sends, expo, gap);
        chkn("idleSends", 0, sends);
        chkn("gap", PERIOD, gap);
        chkv("power", 32'h1, cameraPower_reg);
        for (int k = 0; k < 2; k++) begin
            reset = 1'h1;
            cyc(16);
            reset = 1'h0;
            chkv("power", 32'h0, cameraPower_reg);
            {burstFrameRequest, singleFrameRequest} = 2'h1 << k;
            cyc(1);
            chkv("power", 32'h1, cameraPower_reg);
            {burstFrameRequest, singleFrameRequest} = 2'h0;
        end
        close_out();
    end
endmodule : test_camera_acquisition_control

bind cac_acquisition_ctrl cac_checker chk (.clk, .reset, .regReq,
    .regRdata_reg, .regRvalid_reg, .isoEnable, .singleFrameRequest,
    .burstFrameRequest, .imagingMode, .cameraPower_reg, .autoExposureRun_reg,
    .frameReadout_reg, .frameSend_reg, .exposureCycles_reg, .gainCode_reg,
    .compressEnable_reg, .qualityEff_reg, .bufferTarget_reg);
`default_nettype wire
